// ==== hlcp_apb.v ====
// APB slave register file for the hardwired laser control port.
`timescale 1ns/100ps
`include "hlcp_map.vh"
module hlcp_apb
(
  // Clock and reset
  input  wire        clk,
  input  wire        nrst,
  // APB
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  // Register contents
  output reg  [31:0] ctrl_q,
  output reg  [31:0] proglen_q,
  output reg  [15:0] setpoint_q,
  // Block state
  input  wire [31:0] status,
  input  wire [31:0] inputs,
  input  wire [15:0] analog_in,
  input  wire [3:0]  channel
);
  wire access = psel & penable;
  reg  [31:0] rd_d;
  reg         bad_d;
  // Zero wait states keep the master's timing simple.
  assign pready = 1'b1;
  always @*
  begin
    rd_d  = 32'h0000_0000;
    bad_d = 1'b0;
    case (paddr)
      `HLCP_REG_CTRL:     rd_d = ctrl_q;
      `HLCP_REG_STATUS:   rd_d = status;
      `HLCP_REG_INPUTS:   rd_d = inputs;
      `HLCP_REG_PROGLEN:  rd_d = proglen_q;
      `HLCP_REG_SETPOINT: rd_d = {16'h0000, setpoint_q};
      `HLCP_REG_ANALOG:   rd_d = {16'h0000, analog_in};
      `HLCP_REG_CHANNEL:  rd_d = {28'h0000000, channel};
      default:            bad_d = 1'b1;
    endcase
  end
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_q     <= `HLCP_CTRL_RST;
      proglen_q  <= `HLCP_PROGLEN_RST;
      setpoint_q <= `HLCP_SETPOINT_RST;
      prdata     <= 32'h0000_0000;
      pslverr    <= 1'b0;
    end
    else
    begin
      pslverr <= 1'b0;
      if (psel && !penable)
      begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_d;
        pslverr <= 1'b0;
      end
      if (access)
      begin
        pslverr <= bad_d;
        if (pwrite)
        begin
          case (paddr)
            `HLCP_REG_CTRL:     ctrl_q <= pwdata;
            `HLCP_REG_PROGLEN:  proglen_q <= pwdata;
            `HLCP_REG_SETPOINT: setpoint_q <= pwdata[15:0];
            default:            ctrl_q <= ctrl_q;
          endcase
        end
      end
    end
  end
endmodule

// ==== hlcp_ctl_model.sv ====
// Behavioural machine controller driving the hardwired command lines.
`timescale 1ns/100ps
module hlcp_ctl_model
#(
  parameter CLR_CYCLES = 8
)
(
  // Clock and status
  input  wire       clk,
  input  wire       program_running_out,
  // Command lines
  output reg        emission_request,
  output reg        run_enable,
  output reg        software_control_enable,
  output reg        alarm_clear,
  output reg        guide_beam_request,
  output reg        analog_power_enable,
  output reg        program_abort,
  output reg  [6:0] program_select,
  output reg        sync_in,
  output reg        main_power_control,
  output reg  [3:0] gate_channel_select,
  output reg        pulsed_mode_enable
);
  // ==========================================
  // Controller behaviour
  integer late;
  initial
  begin
    {emission_request, run_enable, software_control_enable, alarm_clear} = 4'h0;
    {guide_beam_request, analog_power_enable, program_abort, sync_in} = 4'h0;
    {main_power_control, pulsed_mode_enable, program_select} = 9'h000;
    gate_channel_select = 4'h0;
    late = 0;
  end
  // The number settles a cycle ahead so the start edge never sees a half-set field.
  task start_prog(input logic [6:0] sel);
    @(posedge clk);
    program_select <= sel;
    @(posedge clk);
    run_enable <= 1'b1;
  endtask
  task finish_prog;
    integer n;
    n = 0;
    while (program_running_out !== 1'b0 && n < 3000)
    begin
      @(negedge clk);
      n = n + 1;
    end
    if (n == 3000)
      late = late + 1;
    @(posedge clk);
    run_enable <= 1'b0;
  endtask
  task clear_alarm;
    @(posedge clk);
    alarm_clear <= 1'b1;
    repeat (CLR_CYCLES + 6) @(posedge clk);
    alarm_clear <= 1'b0;
  endtask
endmodule

// ==== hlcp_map.vh ====
// Constants shared by the hardwired laser control port design.
`ifndef HLCP_MAP_VH
`define HLCP_MAP_VH
// ==========================================
// APB register byte offsets
`define HLCP_REG_CTRL     8'h00
`define HLCP_REG_STATUS   8'h04
`define HLCP_REG_INPUTS   8'h08
`define HLCP_REG_PROGLEN  8'h0c
`define HLCP_REG_SETPOINT 8'h10
`define HLCP_REG_ANALOG   8'h14
`define HLCP_REG_CHANNEL  8'h18
// ==========================================
// Control register fields
`define HLCP_CTRL_FAULT_SET  0
`define HLCP_CTRL_EMIT_OK    1
`define HLCP_CTRL_INTERNAL   2
`define HLCP_CTRL_WAIT_SYNC  3
`define HLCP_CTRL_RST        32'h0000_0002
// ==========================================
// Status register fields
`define HLCP_ST_READY    0
`define HLCP_ST_EMIT     1
`define HLCP_ST_INTERNAL 2
`define HLCP_ST_FAULT    3
`define HLCP_ST_GUIDE    4
`define HLCP_ST_ANALOG   5
`define HLCP_ST_ACK      6
`define HLCP_ST_MAINPWR  7
`define HLCP_ST_RUNNING  8
`define HLCP_ST_DONE     9
`define HLCP_ST_ABTERM   10
`define HLCP_ST_PULSED   11
`define HLCP_ST_SWCTRL   12
`define HLCP_ST_PROGMODE 13
// ==========================================
// Reset values and timing
`define HLCP_PROGLEN_RST  32'h0000_0100
`define HLCP_SETPOINT_RST 16'h0000
`define HLCP_CLK_NS       8
`define HLCP_CLR_MIN_NS   1000000
`define HLCP_CLR_CYCLES   ((`HLCP_CLR_MIN_NS + `HLCP_CLK_NS - 1) / `HLCP_CLK_NS)
`endif

// ==== hlcp_port.v ====
// Top level: control logic behind the hardwired laser control port.
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "hlcp_map.vh"
module hlcp_port
#(
  parameter CLR_CYCLES = `HLCP_CLR_CYCLES,
  parameter HAS_PULSED = 1,
  parameter NUM_GATES  = 3
)
(
  // Clock and reset
  input  wire        clk,
  input  wire        nrst,
  // APB
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Port command inputs
  input  wire        emission_request,
  input  wire        run_enable,
  input  wire        software_control_enable,
  input  wire        alarm_clear,
  input  wire        guide_beam_request,
  input  wire        analog_power_enable,
  input  wire        program_abort,
  input  wire [6:0]  program_select,
  input  wire        sync_in,
  input  wire        main_power_control,
  input  wire [3:0]  gate_channel_select,
  input  wire        pulsed_mode_enable,
  // Analog setpoint, already digitised
  input  wire [15:0] analog_setpoint,
  // Port status outputs
  output reg         ready_out,
  output reg         emitting_out,
  output reg         internal_mode_out,
  output reg         fault_out,
  output reg         guide_beam_out,
  output reg         analog_mode_out,
  output reg         request_ack_out,
  output reg         main_power_out,
  output reg         program_running_out,
  output reg         program_done_out,
  output reg         abnormal_termination_flag,
  // Internal drives
  output reg  [3:0]  gate_open_q,
  output reg         quasi_continuous_pulsing,
  output reg  [15:0] power_setpoint_q
);
  // ==========================================
  // Input synchronisation
  wire [22:0] raw_in = {pulsed_mode_enable, gate_channel_select, main_power_control, sync_in,
                        program_select, program_abort, analog_power_enable, guide_beam_request,
                        alarm_clear, software_control_enable, run_enable, emission_request};
  wire [22:0] s_in;
  hlcp_sync #(.WIDTH(23)) u_sync (.clk(clk), .nrst(nrst), .async_in(raw_in), .sync_out(s_in));
  wire       req_s   = s_in[0];
  wire       run_s   = s_in[1];
  wire       swc_s   = s_in[2];
  wire       clr_s   = s_in[3];
  wire       guide_s = s_in[4];
  wire       ape_s   = s_in[5];
  wire       abort_s = s_in[6];
  wire [6:0] prog_s  = s_in[13:7];
  wire       sync_s  = s_in[14];
  wire       mpc_s   = s_in[15];
  wire [3:0] gate_s  = s_in[19:16];
  wire       pulse_s = s_in[20];
  // ==========================================
  // Edge detection
  reg run_q;
  reg clr_q;
  reg mpc_q;
  wire run_rise = run_s & ~run_q;
  wire clr_rise = clr_s & ~clr_q;
  wire mpc_rise = mpc_s & ~mpc_q;
  wire mpc_fall = ~mpc_s & mpc_q;
  wire run_take = req_s & run_s;
  wire prog_nz  = |prog_s;
  // ==========================================
  // Registers over APB
  wire [31:0] ctrl_q;
  wire [31:0] proglen_q;
  wire [15:0] setpoint_q;
  wire [31:0] status_w;
  hlcp_apb u_apb
  (
    .clk       (clk),
    .nrst      (nrst),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .ctrl_q    (ctrl_q),
    .proglen_q (proglen_q),
    .setpoint_q(setpoint_q),
    .status    (status_w),
    .inputs    ({9'h000, s_in}),
    .analog_in (analog_setpoint),
    .channel   (gate_open_q)
  );
  // ==========================================
  // Program sequencer
  localparam ST_IDLE = 2'b00;
  localparam ST_RUN  = 2'b01;
  localparam ST_WAIT = 2'b10;
  reg  [1:0]  state_q;
  reg  [31:0] count_q;
  reg         alarm_q;
  reg         sync_seen_q;
  // Seventeen bits hold the full one millisecond count at the default clock.
  reg  [16:0] clr_cnt_q;
  wire        running = (state_q != ST_IDLE);
  wire        fault_w = alarm_q | ctrl_q[`HLCP_CTRL_FAULT_SET];
  // The alarm_q clear is qualified by hold time so a glitch cannot wipe a real alarm; abnormal_termination_flag clears on clr_s high unless prog_end_bad.
  wire        clr_done = clr_s && (clr_cnt_q == CLR_CYCLES[16:0] - 17'h00001);
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      run_q       <= 1'b0;
      clr_q       <= 1'b0;
      mpc_q       <= 1'b0;
      state_q     <= ST_IDLE;
      count_q     <= 32'h0000_0000;
      alarm_q     <= 1'b0;
      sync_seen_q <= 1'b0;
      clr_cnt_q   <= 17'h00000;
    end
    else
    begin
      run_q <= run_s;
      clr_q <= clr_s;
      mpc_q <= mpc_s;
      if (!clr_s)
        clr_cnt_q <= 17'h00000;
      else if (clr_rise || (clr_cnt_q != 17'h00000 && clr_cnt_q != CLR_CYCLES[16:0]))
        clr_cnt_q <= clr_cnt_q + 17'h00001;
      if (req_s && clr_done)
        alarm_q <= 1'b0;
      sync_seen_q <= sync_s;
      case (state_q)
        ST_IDLE:
        begin
          count_q <= 32'h0000_0000;
          if (req_s && prog_nz && run_rise && !fault_w)
            state_q <= ST_RUN;
        end
        ST_RUN:
        begin
          count_q <= count_q + 32'h0000_0001;
          if ((req_s && abort_s) || !run_s)
          begin
            state_q <= ST_IDLE;
            alarm_q <= 1'b1;
          end
          else if (ctrl_q[`HLCP_CTRL_WAIT_SYNC] && count_q == {1'b0, proglen_q[31:1]})
            state_q <= ST_WAIT;
          else if (count_q >= proglen_q)
            state_q <= ST_IDLE;
        end
        ST_WAIT:
        begin
          // Program pauses until sync is high on two clocks in a row with the request on, then resumes.
          if ((req_s && abort_s) || !run_s)
          begin
            state_q <= ST_IDLE;
            alarm_q <= 1'b1;
          end
          else if (req_s && sync_s && sync_seen_q)
          begin
            state_q <= ST_RUN;
            count_q <= count_q + 32'h0000_0001;
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end
  wire prog_end_ok  = (state_q == ST_RUN) && !(req_s && abort_s) && run_s &&
                      !(ctrl_q[`HLCP_CTRL_WAIT_SYNC] && count_q == {1'b0, proglen_q[31:1]}) &&
                      (count_q >= proglen_q);
  wire prog_end_bad = running && ((req_s && abort_s) || !run_s);
  // ==========================================
  // Output decode
  wire analog_sel = req_s && ape_s && !prog_nz;
  wire can_emit   = !fault_w && main_power_out && ctrl_q[`HLCP_CTRL_EMIT_OK];
  wire emit_d     = can_emit && req_s && (prog_nz ? running : run_take);
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ready_out                 <= 1'b0;
      emitting_out              <= 1'b0;
      internal_mode_out         <= 1'b0;
      fault_out                 <= 1'b0;
      guide_beam_out            <= 1'b0;
      analog_mode_out           <= 1'b0;
      request_ack_out           <= 1'b0;
      main_power_out            <= 1'b0;
      program_running_out       <= 1'b0;
      program_done_out          <= 1'b0;
      abnormal_termination_flag <= 1'b0;
      gate_open_q               <= 4'h0;
      quasi_continuous_pulsing  <= 1'b0;
      power_setpoint_q          <= 16'h0000;
    end
    else
    begin
      ready_out         <= can_emit;
      emitting_out      <= emit_d;
      internal_mode_out <= ctrl_q[`HLCP_CTRL_INTERNAL] | (req_s & swc_s);
      fault_out         <= fault_w;
      if (req_s)
        guide_beam_out <= guide_s;
      // Analog mode shows where the setpoint comes from, whether or not light is on.
      analog_mode_out <= analog_sel;
      request_ack_out <= req_s;
      if (req_s && mpc_rise)
        main_power_out <= 1'b1;
      else if (req_s && mpc_fall)
        main_power_out <= 1'b0;
      program_running_out <= running;
      if (prog_end_ok)
        program_done_out <= 1'b1;
      else if (!run_s)
        program_done_out <= 1'b0;
      if (prog_end_bad)
        abnormal_termination_flag <= 1'b1;
      else if (clr_s)
        abnormal_termination_flag <= 1'b0;
      if (req_s)
      begin
        if (gate_s != 4'h0 && gate_s <= NUM_GATES[3:0])
          gate_open_q <= gate_s;
        else
          gate_open_q <= 4'h0;
        quasi_continuous_pulsing <= (HAS_PULSED != 0) && pulse_s;
      end
      if (prog_nz)
        power_setpoint_q <= setpoint_q;
      else if (analog_sel)
        power_setpoint_q <= analog_setpoint;
      else
        power_setpoint_q <= 16'h0000;
    end
  end
  assign status_w = {18'h00000, prog_nz, swc_s, quasi_continuous_pulsing,
                     abnormal_termination_flag, program_done_out, program_running_out,
                     main_power_out, request_ack_out, analog_mode_out, guide_beam_out,
                     fault_out, internal_mode_out, emitting_out, ready_out};
endmodule

// ==== hlcp_port_checker.sv ====
// Assertions on the status lines of the hardwired laser control port.
`timescale 1ns/100ps
module hlcp_port_checker
(
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Command lines
  input wire emission_request,
  input wire run_enable,
  input wire program_abort,
  input wire main_power_control,
  input wire guide_beam_request,
  // Status lines
  input wire request_ack_out,
  input wire ready_out,
  input wire fault_out,
  input wire guide_beam_out,
  input wire main_power_out,
  input wire program_running_out,
  input wire program_done_out,
  input wire abnormal_termination_flag
);
  // ==========================================
  // Warm-up
  // Sync stages restart cleared, so the first edges after reset prove nothing.
  reg [2:0] warm_q;
  always @(posedge clk or negedge nrst)
    if (!nrst)
      warm_q <= 3'h0;
    else if (warm_q != 3'h7)
      warm_q <= warm_q + 3'h1;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst || warm_q != 3'h7);
  a_ack_tracks: assert property (request_ack_out == $past(emission_request, 3))
    else $error("Acknowledge does not track the request.");
  a_idle_hold: assert property ((!emission_request) [*6] |-> $stable(main_power_out))
    else $error("Main power moved while not requested.");
  a_guide_on: assert property ($rose(guide_beam_request) && emission_request |-> ##3 guide_beam_out)
    else $error("Guide beam late.");
  a_power_on: assert property ($rose(main_power_control) && emission_request |-> ##3 main_power_out)
    else $error("Main power late.");
  a_abort_stop: assert property (program_running_out && program_abort && emission_request
    |-> ##4 !program_running_out)
    else $error("Abort did not stop the program.");
  a_abort_flag: assert property ($rose(program_abort) && program_running_out && emission_request
    |-> ##3 abnormal_termination_flag ##1 fault_out)
    else $error("Abort left no flag.");
  a_done_clear: assert property ($fell(run_enable) && emission_request |-> ##3 !program_done_out)
    else $error("Done did not clear.");
  a_fault_ready: assert property (fault_out [*2] |-> !ready_out)
    else $error("Ready while faulted.");
endmodule

bind hlcp_port hlcp_port_checker u_chk
(
  .clk, .nrst, .emission_request, .run_enable, .program_abort, .main_power_control,
  .guide_beam_request, .request_ack_out, .ready_out, .fault_out, .guide_beam_out,
  .main_power_out, .program_running_out, .program_done_out, .abnormal_termination_flag
);

// ==== hlcp_port_tb_top.sv ====
// Self-checking bench for the hardwired laser control port.
`timescale 1ns/100ps
module hlcp_port_tb_top;
  reg         clk, nrst, psel, penable, pwrite, rerr;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, rdat;
  reg  [15:0] analog_setpoint;
  integer     bad_count, total_checks, n, cnt;
  wire [31:0] prdata;
  wire [15:0] power_setpoint_q;
  wire [6:0]  program_select;
  wire [3:0]  gate_channel_select, gate_open_q;
  wire        pready, pslverr, emission_request, run_enable, software_control_enable, alarm_clear;
  wire        guide_beam_request, analog_power_enable, program_abort, sync_in, main_power_control;
  wire        pulsed_mode_enable, ready_out, emitting_out, internal_mode_out, fault_out, guide_beam_out;
  wire        analog_mode_out, request_ack_out, main_power_out, program_running_out, program_done_out;
  wire        abnormal_termination_flag, quasi_continuous_pulsing;
  hlcp_port #(.CLR_CYCLES(8)) dut
  (
    .clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .emission_request, .run_enable, .software_control_enable, .alarm_clear, .guide_beam_request,
    .analog_power_enable, .program_abort, .program_select, .sync_in, .main_power_control,
    .gate_channel_select, .pulsed_mode_enable, .analog_setpoint, .ready_out, .emitting_out,
    .internal_mode_out, .fault_out, .guide_beam_out, .analog_mode_out, .request_ack_out,
    .main_power_out, .program_running_out, .program_done_out, .abnormal_termination_flag,
    .gate_open_q, .quasi_continuous_pulsing, .power_setpoint_q
  );
  hlcp_ctl_model #(.CLR_CYCLES(8)) ctl
  (
    .clk, .program_running_out, .emission_request, .run_enable, .software_control_enable,
    .alarm_clear, .guide_beam_request, .analog_power_enable, .program_abort, .program_select,
    .sync_in, .main_power_control, .gate_channel_select, .pulsed_mode_enable
  );
  always #4 clk = ~clk;
  // ==========================================
  // Tasks
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      bad_count = bad_count + 1;
    end
  endtask
  task cy(input integer k);
    repeat (k) @(posedge clk);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer t;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    t = 0;
    do
    begin
      @(posedge clk);
      t = t + 1;
    end
    while (pready !== 1'b1 && t < 20);
    rdat = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk);
    rerr = pslverr;
    @(posedge clk);
    if (t == 20)
    begin
      bad_count = bad_count + 1;
      end_sim;
    end
  endtask
  // Counts negedges until running reaches the wanted level.
  task wait_run(input logic v);
    cnt = 0;
    do
    begin
      @(negedge clk);
      cnt = cnt + 1;
    end
    while (program_running_out !== v && cnt < 3000);
    if (cnt == 3000)
    begin
      bad_count = bad_count + 1;
      end_sim;
    end
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = 43'h0;
    analog_setpoint = 16'h0000;
    bad_count = 0;
    total_checks = 0;
    cy(16);
    nrst <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk(rdat, 32'h2);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rdat, 32'h100);
    apb(1'b0, 8'h40, 32'h0);
    chk(rerr, 1'b1);
    chk(ready_out, 1'b0);
    ctl.emission_request <= 1'b1;
    cy(5);
    chk(request_ack_out, 1'b1);
    ctl.main_power_control <= 1'b1;
    ctl.guide_beam_request <= 1'b1;
    ctl.software_control_enable <= 1'b1;
    ctl.pulsed_mode_enable <= 1'b1;
    cy(5);
    chk(main_power_out, 1'b1);
    chk(ready_out, 1'b1);
    chk(guide_beam_out, 1'b1);
    chk(quasi_continuous_pulsing, 1'b1);
    apb(1'b0, 8'h04, 32'h0);
    chk(rdat[12], 1'b1);
    apb(1'b1, 8'h00, 32'h6);
    cy(3);
    chk(internal_mode_out, 1'b1);
    apb(1'b1, 8'h00, 32'h2);
    for (n = 0; n < 6; n = n + 1)
    begin
      ctl.gate_channel_select <= n[3:0];
      cy(5);
      chk(gate_open_q == 4'h0, n == 0 || n > 3);
    end
    ctl.analog_power_enable <= 1'b1;
    analog_setpoint <= 16'h1234;
    cy(5);
    chk(analog_mode_out, 1'b1);
    chk(power_setpoint_q, 16'h1234);
    ctl.run_enable <= 1'b1;
    cy(5);
    chk(emitting_out, 1'b1);
    chk(program_running_out, 1'b0);
    ctl.run_enable <= 1'b0;
    ctl.analog_power_enable <= 1'b0;
    cy(5);
    chk(emitting_out, 1'b0);
    apb(1'b1, 8'h0c, 32'h10);
    apb(1'b1, 8'h10, 32'h0abc);
    ctl.start_prog(7'h40);
    wait_run(1'b1);
    chk(power_setpoint_q, 16'h0abc);
    chk(emitting_out, 1'b1);
    wait_run(1'b0);
    chk(cnt >= 16 && cnt <= 18, 1'b1);
    chk(program_done_out, 1'b1);
    ctl.finish_prog;
    cy(5);
    chk(program_done_out, 1'b0);
    apb(1'b1, 8'h00, 32'ha);
    ctl.start_prog(7'h05);
    wait_run(1'b1);
    cy(40);
    chk(program_running_out, 1'b1);
    ctl.sync_in <= 1'b1;
    wait_run(1'b0);
    chk(program_done_out, 1'b1);
    ctl.finish_prog;
    ctl.sync_in <= 1'b0;
    apb(1'b1, 8'h00, 32'h2);
    ctl.start_prog(7'h01);
    wait_run(1'b1);
    cy(1);
    ctl.program_abort <= 1'b1;
    cy(5);
    chk(program_running_out, 1'b0);
    chk(abnormal_termination_flag, 1'b1);
    chk(fault_out, 1'b1);
    chk(ready_out, 1'b0);
    ctl.program_abort <= 1'b0;
    ctl.finish_prog;
    ctl.clear_alarm;
    cy(5);
    chk(fault_out, 1'b0);
    chk(abnormal_termination_flag, 1'b0);
    ctl.emission_request <= 1'b0;
    ctl.main_power_control <= 1'b0;
    cy(8);
    chk(main_power_out, 1'b1);
    chk(request_ack_out, 1'b0);
    ctl.emission_request <= 1'b1;
    ctl.main_power_control <= 1'b1;
    cy(5);
    ctl.main_power_control <= 1'b0;
    cy(5);
    chk(main_power_out, 1'b0);
    chk(ctl.late, 0);
    end_sim;
  end
endmodule

// ==== hlcp_sync.v ====
// Two-stage synchroniser for a bus of port inputs.
`timescale 1ns/100ps
module hlcp_sync
#(
  parameter WIDTH = 1
)
(
  // Clock and reset
  input  wire             clk,
  input  wire             nrst,
  // Data
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_q   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
